// >>> ptc_channel.sv
/*
  Pulse-train output channel with APB register access. Emits a counted
  sequence of periods, each a pulse, a pause, or a pulse then a pause, or runs continuously
  in pulse-width mode. Assumes an APB master on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ptc_channel #(
  parameter int unsigned CYC_1MS = ptc_pkg::TB_1MS_CYC,
  parameter int unsigned CYC_100US = ptc_pkg::TB_100US_CYC,
  parameter int unsigned CYC_1US = ptc_pkg::TB_1US_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pulse_out
);
  import ptc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b11
  } ptc_state_t;

  ptc_state_t state_r;
  logic mode_pwm_r;
  logic fmt_analog_r;
  logic [1:0] tb_r;
  logic [15:0] period_r;
  logic [15:0] minp_r;
  logic [15:0] outval_r;
  logic [15:0] count_r;
  logic [15:0] delay_r;
  logic done_r;
  logic start_r;
  logic stop_r;
  logic [15:0] tick_cnt_r;
  logic tick;
  logic [15:0] unit_cnt_r;
  logic [15:0] pulses_left_r;
  logic [15:0] hi_len_r;
  logic [15:0] per_eff;
  logic [15:0] minp_eff;
  logic [15:0] hi_raw;
  logic [15:0] hi_len_nxt;
  logic train_end;

  wire logic wr_acc = psel & penable & pwrite;
  wire logic rd_setup = psel & ~penable & ~pwrite;

  // Unit lengths must fit the 16-bit tick counter
  if (CYC_1MS < 1 || CYC_1MS > 65536) begin : g_chk_1ms
    $error("ptc_channel: CYC_1MS out of range");
  end
  if (CYC_100US < 1 || CYC_100US > 65536) begin : g_chk_100us
    $error("ptc_channel: CYC_100US out of range");
  end
  if (CYC_1US < 1 || CYC_1US > 65536) begin : g_chk_1us
    $error("ptc_channel: CYC_1US out of range");
  end

  // Register address is mapped
  function automatic logic addr_ok(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_PERIOD || a == OFS_MINPULSE ||
           a == OFS_OUTVAL || a == OFS_COUNT || a == OFS_DELAY || a == OFS_STATUS;
  endfunction

  // Clamp a value between two bounds
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= 16'h0000;
    end else if (state_r == ST_IDLE || tick) begin
      tick_cnt_r <= 16'h0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  always_comb begin
    unique case (tb_r)
      PTC_TB_1MS: tick = tick_cnt_r == 16'(CYC_1MS - 1);
      PTC_TB_1US: tick = tick_cnt_r == 16'(CYC_1US - 1);
      default: tick = tick_cnt_r == 16'(CYC_100US - 1);
    endcase
  end

  always_comb begin
    unique case (tb_r)
      PTC_TB_100US: per_eff = clamp16(period_r, PER_MIN_100US, PER_MAX_100US);
      default: per_eff = clamp16(period_r, PER_MIN_MS, PER_MAX_MS);
    endcase
  end

  always_comb begin
    if (tb_r == PTC_TB_100US) begin
      minp_eff = clamp16(minp_r, MINP_LO_100US, {1'b0, per_eff[15:1]});
    end else begin
      minp_eff = clamp16(minp_r, 16'h0000, {1'b0, per_eff[15:1]});
    end
  end

  always_comb begin
    logic [31:0] prod;
    logic [15:0] fs;
    logic [15:0] v;
    fs = fmt_analog_r ? FS_ANALOG : FS_PERMIL;
    v = (outval_r > fs) ? fs : outval_r;
    prod = 32'(v) * 32'(per_eff);
    hi_raw = 16'(prod / 32'(fs));
  end

  always_comb begin
    if (hi_raw < minp_eff) begin
      hi_len_nxt = 16'h0000;
    end else if ((per_eff - hi_raw) < minp_eff) begin
      hi_len_nxt = per_eff;
    end else begin
      hi_len_nxt = hi_raw;
    end
  end

  // Register writes with defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_pwm_r <= 1'b0;
      fmt_analog_r <= 1'b0;
      tb_r <= RST_TB;
      period_r <= RST_PERIOD;
      minp_r <= RST_MINPULSE;
      outval_r <= RST_OUTVAL;
      count_r <= RST_COUNT;
      delay_r <= RST_DELAY;
    end else if (wr_acc) begin
      unique case (paddr)
        OFS_CTRL: begin
          mode_pwm_r <= pwdata[CTRL_MODE];
          fmt_analog_r <= pwdata[CTRL_FMT];
          tb_r <= (pwdata[CTRL_TB_LO +: 2] == 2'h3) ? RST_TB : pwdata[CTRL_TB_LO +: 2];
        end
        OFS_PERIOD: period_r <= pwdata[15:0];
        OFS_MINPULSE: minp_r <= pwdata[15:0];
        OFS_OUTVAL: outval_r <= pwdata[15:0];
        OFS_COUNT: count_r <= pwdata[15:0];
        OFS_DELAY: delay_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Start and stop strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      start_r <= wr_acc && paddr == OFS_CTRL && pwdata[CTRL_START];
      stop_r <= wr_acc && paddr == OFS_CTRL && pwdata[CTRL_STOP];
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      unit_cnt_r <= 16'h0000;
      pulses_left_r <= 16'h0000;
      hi_len_r <= 16'h0000;
    end else if (stop_r) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start_r) begin
            unit_cnt_r <= 16'h0000;
            hi_len_r <= hi_len_nxt;
            pulses_left_r <= count_r;
            if (mode_pwm_r && delay_r != 16'h0000) begin
              state_r <= ST_DELAY;
            end else if (!mode_pwm_r && count_r == 16'h0000) begin
              state_r <= ST_IDLE;
            end else begin
              state_r <= ST_RUN;
            end
          end
        end
        ST_DELAY: begin
          if (tick) begin
            if (unit_cnt_r == delay_r - 16'h0001) begin
              unit_cnt_r <= 16'h0000;
              state_r <= ST_RUN;
            end else begin
              unit_cnt_r <= unit_cnt_r + 16'h0001;
            end
          end
        end
        ST_RUN: begin
          if (tick) begin
            if (unit_cnt_r >= per_eff - 16'h0001) begin
              unit_cnt_r <= 16'h0000;
              hi_len_r <= hi_len_nxt;
              if (!mode_pwm_r) begin
                pulses_left_r <= pulses_left_r - 16'h0001;
                if (pulses_left_r == 16'h0001) begin
                  state_r <= ST_IDLE;
                end
              end
            end else begin
              unit_cnt_r <= unit_cnt_r + 16'h0001;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // last period of a train, or an empty train
  always_comb begin
    train_end = 1'b0;
    if (state_r == ST_IDLE) begin
      train_end = start_r && !mode_pwm_r && count_r == 16'h0000;
    end else if (state_r == ST_RUN && tick && !mode_pwm_r) begin
      train_end = unit_cnt_r >= per_eff - 16'h0001 && pulses_left_r == 16'h0001;
    end
  end

  // done flag; end of train wins over a same-cycle clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else if (train_end) begin
      done_r <= 1'b1;
    end else if (start_r && !stop_r && state_r == ST_IDLE) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state_r == ST_RUN) && !stop_r && (unit_cnt_r < hi_len_r);
    end
  end

  // APB answer, zero wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (rd_setup) begin
        unique case (paddr)
          OFS_CTRL: prdata <= {26'h0, tb_r, fmt_analog_r, mode_pwm_r, 2'b00};
          OFS_PERIOD: prdata <= {16'h0, period_r};
          OFS_MINPULSE: prdata <= {16'h0, minp_r};
          OFS_OUTVAL: prdata <= {16'h0, outval_r};
          OFS_COUNT: prdata <= {16'h0, count_r};
          OFS_DELAY: prdata <= {16'h0, delay_r};
          OFS_STATUS: prdata <= {29'h0, pulse_out, done_r, state_r != ST_IDLE};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // ptc_channel
`default_nettype wire

// >>> ptc_pkg.sv
/*
  Package for the pulse-train output channel: register map, field
  positions, reset values, time-base codes and cycle counts.
  Assumes a 50 MHz system clock.
*/
package ptc_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 50_000_000;

  // Time-base lengths in nanoseconds and derived cycle counts
  localparam int unsigned TB_1MS_NS = 1_000_000;
  localparam int unsigned TB_100US_NS = 100_000;
  localparam int unsigned TB_1US_NS = 1_000;
  localparam int unsigned TB_1MS_CYC = TB_1MS_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned TB_100US_CYC = TB_100US_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned TB_1US_CYC = TB_1US_NS / (1_000_000_000 / CLK_HZ);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_MINPULSE = 8'h08;
  localparam logic [7:0] OFS_OUTVAL = 8'h0c;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_DELAY = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Control field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_FMT = 3;
  localparam int CTRL_TB_LO = 4;

  // Status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_OUT = 2;

  // Time-base codes
  typedef enum logic [1:0] {
    PTC_TB_1MS = 2'h0,
    PTC_TB_100US = 2'h1,
    PTC_TB_1US = 2'h2
  } ptc_tb_t;

  // Reset values
  localparam logic [1:0] RST_TB = 2'h1;
  localparam logic [15:0] RST_PERIOD = 16'h0032;
  localparam logic [15:0] RST_MINPULSE = 16'h0002;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [15:0] RST_OUTVAL = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0001;

  // Output scaling full-scale values
  localparam logic [15:0] FS_PERMIL = 16'h03e8;
  localparam logic [15:0] FS_ANALOG = 16'h6c00;

  // Period and minimum-pulse limits per time base
  localparam logic [15:0] PER_MAX_MS = 16'h0057;
  localparam logic [15:0] PER_MIN_MS = 16'h0001;
  localparam logic [15:0] PER_MAX_100US = 16'h0366;
  localparam logic [15:0] PER_MIN_100US = 16'h0004;
  localparam logic [15:0] MINP_LO_100US = 16'h0002;

endpackage : ptc_pkg

// >>> ptc_channel_assertions.sv
/* Port checker for ptc_channel: bus answers and output pulse width.
   Assumes the 1 us time base or longer, so a unit is 50 cycles or more. */
`timescale 1ns/100ps
`default_nettype none
module ptc_channel_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pulse_out
);
  import ptc_pkg::*;
  int unsigned hi_cnt_r;
  wire logic bad_a;
  wire logic rd_ok;
  assign bad_a = (paddr > OFS_STATUS) || (paddr[1:0] != 2'h0);
  assign rd_ok = pready && !pwrite && !pslverr;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) hi_cnt_r <= 0;
    else hi_cnt_r <= pulse_out ? hi_cnt_r + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_src; pready |-> $past(psel && !penable) && penable; endproperty
  a_ready_src: assert property (p_ready_src) else $error("stray ready");
  property p_err_unmap; pready && bad_a |-> pslverr; endproperty
  a_err_unmap: assert property (p_err_unmap) else $error("unmapped not refused");
  property p_err_map; pslverr |-> pready && bad_a; endproperty
  a_err_map: assert property (p_err_map) else $error("mapped refused");
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not 0");
  property p_ctrl_rd; rd_ok && paddr == OFS_CTRL |-> prdata[1:0] == 2'h0; endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("strobe bits read 1");
  property p_upper; rd_ok |-> prdata[31:16] == 16'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_min_high; $fell(pulse_out) |-> hi_cnt_r >= TB_1US_CYC; endproperty
  a_min_high: assert property (p_min_high) else $error("pulse too short");
endmodule // ptc_channel_assertions
`default_nettype wire

// >>> pulse_train_output_channel_bench.sv
/* Self-checking bench for ptc_channel over APB.
   Assumes the 1 us time base, 50 cycles a unit. */
`timescale 1ns/100ps
`default_nettype none
module pulse_train_output_channel_bench;
  import ptc_pkg::*;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pulse_out, pready, pslverr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic prev = 0, er;
  int bad_count = 0, tests_run = 0, hi = 0, rises = 0, h0, r0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (pulse_out === 1'b1) hi++;
    if (pulse_out === 1'b1 && prev === 1'b0) rises++;
    prev <= pulse_out;
  end
  ptc_channel u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk) penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge clk);
  endtask
  task automatic run(logic [31:0] c, int per, int ov, int cnt, int mp, int eh, int er_n);
    apb(1, OFS_PERIOD, per); apb(1, OFS_OUTVAL, ov); apb(1, OFS_COUNT, cnt);
    apb(1, OFS_MINPULSE, mp); apb(1, OFS_DELAY, 7);
    h0 = hi; r0 = rises;
    apb(1, OFS_CTRL, c | 32'h21);
    repeat (per * cnt * TB_1US_CYC + 100) @(posedge clk);
    chk("high cycles", eh * TB_1US_CYC, hi - h0);
    chk("pulses", er_n, rises - r0);
    chk("idle", 0, pulse_out);
    apb(0, OFS_STATUS, 0); chk("done", 1, rd[STAT_DONE]);
    $display("test ended ov %0d", ov);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400_000 bad_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    apb(0, OFS_CTRL, 0); chk("tb", 32'h10, rd);
    apb(0, OFS_PERIOD, 0); chk("period", 32'h32, rd);
    apb(0, OFS_MINPULSE, 0); chk("minp", 32'h2, rd);
    apb(0, OFS_DELAY, 0); chk("delay", 32'h0, rd);
    apb(0, 8'h1c, 0); chk("err", 1, er);
    $display("test ended reset");
    run(0, 10, 500, 3, 0, 15, 3);
    run(32'h8, 10, 13824, 2, 0, 10, 2);
    run(0, 10, 200, 3, 3, 0, 0);
    run(0, 10, 600, 3, 8, 30, 1);
    apb(1, OFS_MINPULSE, 0);
    h0 = rises;
    apb(1, OFS_CTRL, 32'h25);
    repeat (300) @(posedge clk);
    chk("pwm delay", 0, rises - h0);
    repeat (1300) @(posedge clk);
    chk("pwm runs", 1, rises - h0 >= 3);
    apb(0, OFS_STATUS, 0); chk("busy", 1, rd[STAT_BUSY]);
    chk("out bit", 1, rd[STAT_OUT]);
    apb(1, OFS_CTRL, 32'h26);
    repeat (600) @(posedge clk);
    chk("pwm stop", 0, pulse_out);
    $display("test ended pwm");
    test_done();
  end
endmodule // pulse_train_output_channel_bench
bind ptc_channel ptc_channel_assertions u_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out));
`default_nettype wire
